/* design/pcr_pkg.sv */
// constants of the configuration header slice at offsets 0x2c..0x3b
// assumes a 100 MHz bus clock and one option rom on byte-wide data pins
package pcr_pkg;

   // configuration dword byte offsets
   localparam logic [7:0]  OFF_SUBSYS_ID   = 8'h2c;
   localparam logic [7:0]  OFF_ROM_BASE    = 8'h30;
   localparam logic [7:0]  OFF_CAP_HEAD    = 8'h34;
   localparam logic [7:0]  OFF_RSVD        = 8'h38;
   localparam logic [7:0]  OFF_ID_ALIAS    = 8'h40;

   // rom window layout: base in bits 31:22, image of 64 kbyte at the bottom
   localparam int          ROM_BASE_LSB    = 22;
   localparam int          ROM_BASE_W      = 10;
   localparam int          ROM_IMAGE_AW    = 16;
   localparam int          ROM_DECODE_BIT  = 0;

   // values after reset
   localparam logic [9:0]  ROM_BASE_RST    = 10'h000;
   localparam logic        ROM_DECODE_RST  = 1'b0;
   localparam logic [31:0] ID_RST          = 32'h0000_0000;
   localparam logic [7:0]  CAP_HEAD_RST    = 8'h00;

   // capability list head per power-on configuration
   localparam logic [7:0]  CAP_HEAD_PCI    = 8'h00;
   localparam logic [7:0]  CAP_HEAD_AGP    = 8'h44;
   localparam logic [7:0]  CAP_HEAD_PM     = 8'h60;

   // identification bytes inside the option rom image
   localparam logic [15:0] ROM_ID_ADDR     = 16'h0054;
   localparam logic [1:0]  ROM_ID_LAST     = 2'h3;

   // timing
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          ROM_ACCESS_NS   = 150;
   localparam int          ROM_ACCESS_CYC  =
      (ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SYNC_STAGES     = 2;
   localparam int          ROM_WAIT_CYC    = ROM_ACCESS_CYC + SYNC_STAGES;
   localparam int          CNT_W           = 5;

   typedef enum logic [4:0] {
      ST_SETTLE = 5'h01,
      ST_STRAP  = 5'h02,
      ST_ADDR   = 5'h04,
      ST_WAIT   = 5'h08,
      ST_READY  = 5'h10
   } pcr_init_e;

endpackage

/* design/pcr_sync.sv */
// two-flop synchroniser for pins from outside the bus clock domain
// assumes each bit is an independent level, no word coherence is given
module pcr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_n_i,
   input  wire logic         clk_en_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_r <= '0;
         q_o    <= '0;
      end else if (clk_en_i) begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule

/* design/pcr_rom_decode.sv */
// expansion rom window decoder, one cycle from request to claim
// assumes memory request and address come from logic on the bus clock
module pcr_rom_decode (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        mem_req_i,
   input  wire logic [31:0] mem_addr_i,
   input  wire logic        mem_space_en_i,
   input  wire logic        decode_en_i,
   input  wire logic [9:0]  base_i,
   output logic             hit_o,
   output logic [15:0]      offset_o
);
   wire in_window = mem_addr_i[31:pcr_pkg::ROM_BASE_LSB] == base_i;
   // only the bottom 64 kbyte of the 4 mbyte window holds the image
   wire in_image  = mem_addr_i[pcr_pkg::ROM_BASE_LSB-1:
                               pcr_pkg::ROM_IMAGE_AW] == '0;
   wire claim     = mem_req_i && mem_space_en_i && decode_en_i
                    && in_window && in_image;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hit_o    <= 1'b0;
         offset_o <= 16'h0000;
      end else if (clk_en_i) begin
         hit_o    <= claim;
         offset_o <= claim ? mem_addr_i[15:0] : 16'h0000;
      end
   end
endmodule

/* design/pcr_cfg_slice.sv */
// configuration header slice 0x2c..0x3b plus the writable id alias at 0x40
// assumes config requests come from bus-clock logic, straps and rom pins
// come from outside and are synchronised here
//
// Overview of operation
// - upper half of 0x2c returns the product subsystem code, read-only
// - lower half of 0x2c is the maker code; a reset strap picks its source
// - in rom strap mode, id bytes load from rom 0x54..0x57 at reset
// - otherwise the id bytes come from config writes to 0x40..0x43
// - the writable id at 0x40 reads back as read-only copy at 0x2c
// - rom base bits 31:22 are writable, window aligned to 4 mbyte
// - rom base bits 21:11 read zero and ignore writes
// - the 64 kbyte rom image sits at the bottom of the window
// - rom base bit 0 enables rom decoding, resets to zero
// - rom accesses claimed only with memory space and decode enabled
// - capability head reads 0x00 for pci host without power management
// - capability head reads 0x44 for agp host without power management
// - capability head reads 0x60 with power management, upper bits zero
// - dword 0x38 reads all zero and ignores writes
module pcr_cfg_slice (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        cfg_req_i,
   input  wire logic        cfg_we_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [3:0]  cfg_be_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic      [31:0] cfg_rdata_o,
   output logic             cfg_ack_o,
   input  wire logic        mem_space_en_i,
   input  wire logic        mem_req_i,
   input  wire logic [31:0] mem_addr_i,
   output logic             rom_hit_o,
   output logic      [15:0] rom_offset_o,
   input  wire logic        strap_rom_id_i,
   input  wire logic        por_agp_host_i,
   input  wire logic        por_pm_support_i,
   input  wire logic [7:0]  rom_data_i,
   output logic      [15:0] rom_fetch_addr_o,
   output logic             rom_fetch_rd_o,
   output logic             init_done_o
);
   pcr_pkg::pcr_init_e state_r;
   pcr_pkg::pcr_init_e state_nxt;

   logic [pcr_pkg::CNT_W-1:0] cnt_r;
   logic [1:0]                byte_idx_r;
   logic [31:0]               id_r;
   logic [9:0]                base_r;
   logic                      decode_r;
   logic [7:0]                cap_head_r;
   logic                      rom_mode_r;
   logic [2:0]                strap_sync;
   logic [7:0]                rom_data_sync;

   pcr_sync #(
      .W (3)
   ) u_strap_sync (
      .clk_i     (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .d_i       ({strap_rom_id_i, por_agp_host_i, por_pm_support_i}),
      .q_o       (strap_sync)
   );

   pcr_sync #(
      .W (8)
   ) u_rom_data_sync (
      .clk_i     (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .d_i       (rom_data_i),
      .q_o       (rom_data_sync)
   );

   pcr_rom_decode u_rom_decode (
      .clk_i          (sys_clk_i),
      .reset_n_i      (reset_n_i),
      .clk_en_i       (clk_en_i),
      .mem_req_i      (mem_req_i),
      .mem_addr_i     (mem_addr_i),
      .mem_space_en_i (mem_space_en_i),
      .decode_en_i    (decode_r),
      .base_i         (base_r),
      .hit_o          (rom_hit_o),
      .offset_o       (rom_offset_o)
   );

   // address decode; requests wait until the reset-time load is over
   wire       ready     = state_r == pcr_pkg::ST_READY;
   wire       cfg_take  = cfg_req_i && clk_en_i && ready;
   wire       cfg_wr    = cfg_take && cfg_we_i;
   wire [5:0] word      = cfg_addr_i[7:2];
   wire       sel_id    = word == pcr_pkg::OFF_SUBSYS_ID[7:2];
   wire       sel_base  = word == pcr_pkg::OFF_ROM_BASE[7:2];
   wire       sel_cap   = word == pcr_pkg::OFF_CAP_HEAD[7:2];
   wire       sel_alias = word == pcr_pkg::OFF_ID_ALIAS[7:2];

   // read data; 0x38 and every unmapped dword fall through to zero
   wire [31:0] rd_id    = id_r;
   wire [31:0] rd_base  = {base_r, 11'h000, 10'h000,
                           decode_r};
   wire [31:0] rd_cap   = {24'h000000, cap_head_r};
   wire [31:0] rd_data  = (sel_id || sel_alias) ? rd_id   :
                          sel_base              ? rd_base :
                          sel_cap               ? rd_cap  :
                          32'h0000_0000;

   // only 0x40 and the writable parts of 0x30 store anything
   wire        wr_alias = cfg_wr && sel_alias;
   wire        wr_base  = cfg_wr && sel_base;
   wire [31:0] alias_merged;
   assign alias_merged[31:24] = cfg_be_i[3] ? cfg_wdata_i[31:24] : id_r[31:24];
   assign alias_merged[23:16] = cfg_be_i[2] ? cfg_wdata_i[23:16] : id_r[23:16];
   assign alias_merged[15:8]  = cfg_be_i[1] ? cfg_wdata_i[15:8]  : id_r[15:8];
   assign alias_merged[7:0]   = cfg_be_i[0] ? cfg_wdata_i[7:0]   : id_r[7:0];

   wire [9:0] base_merged = {cfg_be_i[3] ? cfg_wdata_i[31:24] : base_r[9:2],
                             cfg_be_i[2] ? cfg_wdata_i[23:22] : base_r[1:0]};
   wire       decode_merged = cfg_be_i[0] ? cfg_wdata_i[pcr_pkg::ROM_DECODE_BIT]
                                          : decode_r;

   // power management outranks the host interface choice
   wire [7:0] cap_pick = strap_sync[0] ? pcr_pkg::CAP_HEAD_PM  :
                         strap_sync[1] ? pcr_pkg::CAP_HEAD_AGP :
                                         pcr_pkg::CAP_HEAD_PCI;

   wire fetch_byte_done = state_r == pcr_pkg::ST_WAIT && cnt_r == '0;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pcr_pkg::ST_SETTLE: begin
            if (cnt_r == '0) begin
               state_nxt = pcr_pkg::ST_STRAP;
            end
         end
         pcr_pkg::ST_STRAP: begin
            state_nxt = strap_sync[2] ? pcr_pkg::ST_ADDR
                                      : pcr_pkg::ST_READY;
         end
         pcr_pkg::ST_ADDR: begin
            state_nxt = pcr_pkg::ST_WAIT;
         end
         pcr_pkg::ST_WAIT: begin
            if (cnt_r == '0) begin
               state_nxt = (byte_idx_r == pcr_pkg::ROM_ID_LAST)
                           ? pcr_pkg::ST_READY : pcr_pkg::ST_ADDR;
            end
         end
         pcr_pkg::ST_READY: begin
            state_nxt = pcr_pkg::ST_READY;
         end
         default: begin
            state_nxt = pcr_pkg::ST_SETTLE;
         end
      endcase
   end

   // straps are sampled only once the synchroniser holds post-reset levels
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= pcr_pkg::ST_SETTLE;
         cnt_r   <= pcr_pkg::CNT_W'(pcr_pkg::SYNC_STAGES);
      end else if (clk_en_i) begin
         state_r <= state_nxt;
         if (state_nxt == pcr_pkg::ST_WAIT
             && state_r == pcr_pkg::ST_ADDR) begin
            cnt_r <= pcr_pkg::CNT_W'(pcr_pkg::ROM_WAIT_CYC - 1);
         end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rom_mode_r <= 1'b0;
         cap_head_r <= pcr_pkg::CAP_HEAD_RST;
      end else if (clk_en_i && state_r == pcr_pkg::ST_STRAP) begin
         rom_mode_r <= strap_sync[2];
         cap_head_r <= cap_pick;
      end
   end

   // rom fetch: one byte per address phase, lowest byte first
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         byte_idx_r       <= 2'h0;
         rom_fetch_addr_o <= 16'h0000;
         rom_fetch_rd_o   <= 1'b0;
      end else if (clk_en_i) begin
         if (state_r == pcr_pkg::ST_ADDR) begin
            rom_fetch_addr_o <= pcr_pkg::ROM_ID_ADDR
                                + {14'h0000, byte_idx_r};
            rom_fetch_rd_o   <= 1'b1;
         end else if (fetch_byte_done) begin
            byte_idx_r       <= byte_idx_r + 1'b1;
            rom_fetch_rd_o   <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         id_r <= pcr_pkg::ID_RST;
      end else if (clk_en_i) begin
         if (fetch_byte_done) begin
            id_r[{byte_idx_r, 3'b000} +: 8] <= rom_data_sync;
         end else if (wr_alias) begin
            id_r <= alias_merged;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         base_r   <= pcr_pkg::ROM_BASE_RST;
         decode_r <= pcr_pkg::ROM_DECODE_RST;
      end else if (clk_en_i && wr_base) begin
         base_r   <= base_merged;
         decode_r <= decode_merged;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_ack_o   <= 1'b0;
         cfg_rdata_o <= 32'h0000_0000;
         init_done_o <= 1'b0;
      end else if (clk_en_i) begin
         cfg_ack_o   <= cfg_take;
         cfg_rdata_o <= (cfg_take && !cfg_we_i) ? rd_data : 32'h0000_0000;
         init_done_o <= state_nxt == pcr_pkg::ST_READY;
      end
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   wire rd_take = cfg_take && !cfg_we_i;

   sequence s_fetch_addr;
      clk_en_i && state_r == pcr_pkg::ST_ADDR;
   endsequence

   sequence s_fetch_issued;
      rom_fetch_rd_o && rom_fetch_addr_o >= pcr_pkg::ROM_ID_ADDR
      && rom_fetch_addr_o <= pcr_pkg::ROM_ID_ADDR + 16'h0003;
   endsequence

   a_product_code_ro: assert property (
      rd_take && sel_id |=> cfg_ack_o && cfg_rdata_o[31:16] == id_r[31:16])
      else $error("product code read mismatch");

   a_alias_source_zero: assert property (
      clk_en_i && state_r == pcr_pkg::ST_STRAP && !strap_sync[2]
      |=> ready && !rom_mode_r && id_r == pcr_pkg::ID_RST)
      else $error("alias strap mode did not go straight to ready");

   a_fetch_rom_addr: assert property (
      s_fetch_addr |=> s_fetch_issued)
      else $error("rom fetch address outside id bytes");

   a_fetch_byte_load: assert property (
      clk_en_i && fetch_byte_done && !$past(wr_alias)
      |=> id_r[{$past(byte_idx_r), 3'b000} +: 8] == $past(rom_data_sync))
      else $error("fetched rom byte not stored");

   a_alias_write: assert property (
      wr_alias && cfg_be_i == 4'hf |=> id_r == $past(cfg_wdata_i))
      else $error("alias dword write lost");

   a_alias_mirror: assert property (
      rd_take && sel_id ##1 rd_take && sel_alias
      |=> cfg_rdata_o == $past(cfg_rdata_o) || $past(wr_alias, 2))
      else $error("0x2c and 0x40 disagree");

   a_base_write: assert property (
      wr_base && cfg_be_i == 4'hf
      |=> base_r == $past(cfg_wdata_i[31:22])
          && decode_r == $past(cfg_wdata_i[0]))
      else $error("rom base write lost");

   a_base_low_zero: assert property (
      rd_take && sel_base |=> cfg_ack_o && cfg_rdata_o[21:1] == 21'h000000)
      else $error("rom base low bits not zero");

   a_rom_claim: assert property (
      clk_en_i && mem_req_i && !(mem_space_en_i && decode_r) |=> !rom_hit_o)
      else $error("rom claimed while disabled");

   a_rom_image: assert property (
      clk_en_i && mem_req_i && mem_space_en_i && decode_r
      && mem_addr_i[31:16] == {base_r, 6'h00}
      |=> rom_hit_o && rom_offset_o == $past(mem_addr_i[15:0]))
      else $error("rom image access not claimed");

   a_cap_head_value: assert property (
      rd_take && sel_cap
      |=> cfg_rdata_o[31:8] == 24'h000000
          && cfg_rdata_o[7:0] == (strap_sync[0] ? pcr_pkg::CAP_HEAD_PM  :
                                  strap_sync[1] ? pcr_pkg::CAP_HEAD_AGP :
                                                  pcr_pkg::CAP_HEAD_PCI))
      else $error("capability head value wrong");

   a_rsvd_zero: assert property (
      rd_take && word == pcr_pkg::OFF_RSVD[7:2] |=> cfg_rdata_o == '0)
      else $error("reserved dword not zero");

   a_ro_write_ignored: assert property (
      cfg_wr && (sel_id || sel_cap || word == pcr_pkg::OFF_RSVD[7:2])
      |=> $stable(id_r) && $stable(base_r) && $stable(cap_head_r))
      else $error("read-only write changed state");
endmodule

/* verif/pcr_rom_model.sv */
// option rom on the byte-wide data pins, seen from the id fetch logic
// assumes the fetch address is held for the whole byte read
module pcr_rom_model #(
   parameter logic [7:0] SALT = 8'h3c
) (
   input  wire logic [15:0] fetch_addr_i,
   input  wire logic        fetch_rd_i,
   output logic      [7:0]  rom_data_o
);
   timeunit 1ns;
   timeprecision 100ps;

   function automatic logic [7:0] img(input logic [15:0] a);
      return {a[3:0], a[7:4]} ^ SALT ^ a[15:8];
   endfunction

   initial rom_data_o = 8'h00;

   // pins turn over at once on any change, so a stale byte is never seen;
   // valid data follows well inside the 150 ns access time
   always @(fetch_addr_i or fetch_rd_i) begin
      rom_data_o = ~rom_data_o;
      if (fetch_rd_i) begin
         rom_data_o <= #90 img(fetch_addr_i);
      end
   end
endmodule

/* verif/tb_pcr_cfg_slice.sv */
// self-checking bench for the configuration header slice 0x2c..0x3b
// assumes one 100 MHz clock; the option rom is the model beside it
module tb_pcr_cfg_slice;
   timeunit 1ns;
   timeprecision 100ps;

   logic        sys_clk_i, reset_n_i, clk_en_i;
   logic        cfg_req_i, cfg_we_i;
   logic [7:0]  cfg_addr_i;
   logic [3:0]  cfg_be_i;
   logic [31:0] cfg_wdata_i, cfg_rdata_o;
   logic        cfg_ack_o, mem_space_en_i, mem_req_i;
   logic [31:0] mem_addr_i;
   logic        rom_hit_o;
   logic [15:0] rom_offset_o, rom_fetch_addr_o;
   logic        strap_rom_id_i, por_agp_host_i, por_pm_support_i;
   logic [7:0]  rom_data_i;
   logic        rom_fetch_rd_o, init_done_o;
   int          err_total, checks_done, cyc;
   logic [31:0] id_m, rb_m, w, v, m;
   logic [9:0]  base;
   logic [15:0] off;

   pcr_cfg_slice pcr_cfg_slice_i (.*);
   pcr_rom_model pcr_rom_model_i (.fetch_addr_i(rom_fetch_addr_o),
      .fetch_rd_i(rom_fetch_rd_o), .rom_data_o(rom_data_i));

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ceiling: all resets and transfers take well under 20000 cycles
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   function automatic logic [31:0] bm(logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [7:0] romb(logic [15:0] a);
      return {a[3:0], a[7:4]} ^ 8'h3c ^ a[15:8];
   endfunction

   // one config transfer; request held until the taking edge
   task automatic cfg(input logic we, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge sys_clk_i);
      #1;
      cfg_req_i = 1'b1;
      cfg_we_i = we;
      cfg_addr_i = a;
      cfg_be_i = be;
      cfg_wdata_i = wd;
      @(posedge sys_clk_i);
      #1;
      cfg_req_i = 1'b0;
      rd = cfg_rdata_o;
      chk("cfg_ack_o", 32'h1, {31'h0, cfg_ack_o});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      cfg(1'b0, a, 4'hf, 32'h0, r);
      chk($sformatf("cfg_rdata_o@%h", a), e, r);
   endtask

   task automatic mem(input logic [31:0] a, input logic hit);
      @(posedge sys_clk_i);
      #1;
      mem_req_i = 1'b1;
      mem_addr_i = a;
      @(posedge sys_clk_i);
      #1;
      mem_req_i = 1'b0;
      chk("rom_hit_o", {31'h0, hit}, {31'h0, rom_hit_o});
      chk("rom_offset_o", hit ? {16'h0, a[15:0]} : 32'h0,
          {16'h0, rom_offset_o});
   endtask

   task automatic do_reset(input logic s, input logic g, input logic p);
      int n;
      reset_n_i = 1'b0;
      strap_rom_id_i = s;
      por_agp_host_i = g;
      por_pm_support_i = p;
      repeat (2) @(posedge sys_clk_i);
      #1;
      reset_n_i = 1'b1;
      id_m = 32'h0;
      rb_m = 32'h0;
      n = 0;
      if (s) begin
         // a request during the fetch must be ignored
         repeat (5) @(posedge sys_clk_i);
         #1;
         cfg_req_i = 1'b1;
         cfg_we_i = 1'b0;
         @(posedge sys_clk_i);
         #1;
         cfg_req_i = 1'b0;
         chk("early cfg_ack_o", 32'h0, {31'h0, cfg_ack_o});
      end
      while (init_done_o !== 1'b1 && n < 300) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      chk("init_done_o", 32'h1, {31'h0, init_done_o});
      if (!s) begin
         chk("init cycles", 32'(pcr_pkg::SYNC_STAGES + 2), n);
      end
   endtask

   initial begin
      reset_n_i = 1'b0;
      clk_en_i = 1'b1;
      cfg_req_i = 1'b0;
      cfg_we_i = 1'b0;
      cfg_addr_i = 8'h00;
      cfg_be_i = 4'h0;
      cfg_wdata_i = 32'h0;
      mem_space_en_i = 1'b0;
      mem_req_i = 1'b0;
      mem_addr_i = 32'h0;
      strap_rom_id_i = 1'b0;
      por_agp_host_i = 1'b0;
      por_pm_support_i = 1'b0;
      err_total = 0;
      checks_done = 0;
      cyc = 0;
      void'($urandom(32'he484));
      for (int i = 0; i < 4; i++) begin
         do_reset(1'b0, i[0], i[1]);
         rd_chk(8'h34, i[1] ? 32'h60
                : (i[0] ? 32'h44 : 32'h0));
         rd_chk(8'h30, 32'h0);
         rd_chk(8'h38, 32'h0);
      end
      // alias writes, then writes aimed at read-only places
      repeat (6) begin
         w = $urandom;
         m = bm(4'($urandom));
         cfg(1'b1, 8'h40, m[24] ? 4'hf : {m[24], m[16], m[8], m[0]}, w, v);
         if (m[24]) m = 32'hffff_ffff;
         id_m = (id_m & ~m) | (w & m);
         rd_chk(8'h2c, id_m);
         cfg(1'b1, 8'h2c, 4'hf, $urandom, v);
         cfg(1'b1, 8'h34, 4'hf, $urandom, v);
         cfg(1'b1, 8'h38, 4'hf, $urandom, v);
         rd_chk(8'h2c, id_m);
         rd_chk(8'h34, 32'h60);
         rd_chk(8'h38, 32'h0);
      end
      // back-to-back reads of the id and its writable alias
      @(posedge sys_clk_i);
      #1;
      cfg_req_i = 1'b1;
      cfg_we_i = 1'b0;
      cfg_addr_i = 8'h2c;
      @(posedge sys_clk_i);
      #1;
      chk("cfg_rdata_o@2c b2b", id_m, cfg_rdata_o);
      cfg_addr_i = 8'h40;
      @(posedge sys_clk_i);
      #1;
      cfg_req_i = 1'b0;
      chk("cfg_rdata_o@40 b2b", id_m, cfg_rdata_o);
      // a low clock enable must drop a request and freeze the id
      @(posedge sys_clk_i);
      #1;
      clk_en_i = 1'b0;
      cfg_req_i = 1'b1;
      cfg_we_i = 1'b1;
      cfg_addr_i = 8'h40;
      cfg_be_i = 4'hf;
      cfg_wdata_i = ~id_m;
      repeat (2) @(posedge sys_clk_i);
      #1;
      cfg_req_i = 1'b0;
      chk("frozen cfg_ack_o", 32'h0, {31'h0, cfg_ack_o});
      clk_en_i = 1'b1;
      rd_chk(8'h2c, id_m);
      repeat (8) begin
         w = $urandom;
         m = bm(4'($urandom));
         cfg(1'b1, 8'h30, {m[24], m[16], m[8], m[0]}, w, v);
         rb_m = ((rb_m & ~m) | (w & m)) & 32'hffc0_0001;
         rd_chk(8'h30, rb_m);
      end
      for (int k = 0; k < 4; k++) begin
         base = 10'($urandom);
         off = 16'($urandom);
         cfg(1'b1, 8'h30, 4'hf, {base, 21'h1ffff5, k[1]}, v);
         mem_space_en_i = k[0];
         mem({base, 6'h00, off}, k == 3);
         mem({base, 6'h01, off}, 1'b0);
         mem({base ^ 10'h200, 6'h00, off}, 1'b0);
         rd_chk(8'h30, {base, 21'h0, k[1]});
      end
      do_reset(1'b1, 1'b1, 1'b0);
      rd_chk(8'h2c, {romb(16'h57), romb(16'h56), romb(16'h55),
                     romb(16'h54)});
      rd_chk(8'h34, 32'h44);
      print_verdict();
   end
endmodule
